// File: inc/vdc_pkg.sv
package vdc_pkg;

    // register byte addresses on the bus
    localparam logic [11:0] ADDR_CODE_HIGH = 12'h000;
    localparam logic [11:0] ADDR_CODE_LOW  = 12'h004;
    localparam logic [11:0] ADDR_CONTROL   = 12'h008;
    localparam logic [11:0] ADDR_STATUS    = 12'h00C;

    localparam logic [7:0]  RESET_CODE_HIGH = 8'h00;
    localparam logic [7:0]  RESET_CODE_LOW  = 8'h00;
    localparam logic [7:0]  RESET_CONTROL   = 8'h00;

    localparam int          ENABLE_BIT      = 0;
    localparam int          STATUS_SETTLED  = 0;
    localparam int          STATUS_BUSY     = 1;

    // analog settling time and conversion cycle length
    localparam int          SETTLE_TIME_NS  = 10000;
    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CONV_CYCLES     = 4;

    localparam logic [1:0]  HTRANS_NONSEQ   = 2'b10;
    localparam logic [2:0]  HSIZE_WORD      = 3'b010;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
    } vdc_acc_s;

    typedef struct packed
    {
        logic        enable;
        logic [15:0] code;
        logic        load;
    } vdc_dac_s;

endpackage

// File: rtl/vdc_settle.sv
`timescale 1ns/1ns
module vdc_settle
(
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic enable,
    input  wire logic load,
    output logic      settled,
    output logic      busy
);

    logic [15:0] settle_reg;
    logic [15:0] settle_next;
    logic [3:0]  conv_reg;
    logic [3:0]  conv_next;

    // settle count restarts whenever the analog part is off
    assign settle_next = !enable ? 16'h0000 :
                         (settle_reg == 16'(vdc_pkg::SETTLE_CYCLES)) ? settle_reg :
                         settle_reg + 16'h0001;
    assign conv_next   = load ? 4'(vdc_pkg::CONV_CYCLES) :
                         (conv_reg != 4'h0) ? conv_reg - 4'h1 : 4'h0;
    assign settled     = enable && (settle_reg == 16'(vdc_pkg::SETTLE_CYCLES));
    assign busy        = (conv_reg != 4'h0);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            settle_reg <= 16'h0000;
            conv_reg   <= 4'h0;
        end
        else
        begin
            settle_reg <= settle_next;
            conv_reg   <= conv_next;
        end
    end

    a_busy_after_load : assert property (@(posedge mclk) disable iff (!resetn)
        load |=> busy [*4]) else $error("busy too short");
    a_busy_ends : assert property (@(posedge mclk) disable iff (!resetn)
        !load [*5] |-> !busy) else $error("busy too long");
    a_settle_off_clear : assert property (@(posedge mclk) disable iff (!resetn)
        !enable |-> !settled) else $error("settled while disabled");

endmodule

// File: rtl/vdc_top.sv
`timescale 1ns/1ns
// Behaviour
// - converter code is two bytes: high holds bits 15..8, low holds 7..0
// - each high-byte write loads full 16-bit code and starts conversion
// - low-byte write only fills shadow buffer, output unchanged
// - high-byte write copies shadow into low-byte register same cycle
// - control bit 0 is converter enable, 1 enables, 0 disables
// - enable cleared powers analog circuitry down
// - control bits 7..1 read zero and ignore writes
module vdc_top
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic [15:0]      converter_code,
    output logic             converter_load,
    output logic             converter_power_down
);

    vdc_pkg::vdc_acc_s acc_reg;
    vdc_pkg::vdc_acc_s acc_next;
    logic [7:0]        code_high_reg;
    logic [7:0]        code_low_reg;
    logic [7:0]        shadow_reg;
    logic              enable_reg;
    logic [7:0]        code_high_next;
    logic [7:0]        code_low_next;
    logic [7:0]        shadow_next;
    logic              enable_next;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    vdc_pkg::vdc_dac_s dac_reg;
    vdc_pkg::vdc_dac_s dac_next;
    logic              settled;
    logic              busy;
    wire               take;
    wire               wr_high;
    wire               wr_low;
    wire               wr_ctrl;
    wire               rd_now;
    wire [7:0]         wbyte;

    function automatic logic hit(input vdc_pkg::vdc_acc_s a, input logic [11:0] off);
        hit = (a.addr == off);
    endfunction

    // address phase accepted when selected, bus ready and a nonsequential transfer; hsize is not checked
    assign take     = hsel && hready && (htrans == vdc_pkg::HTRANS_NONSEQ);
    assign acc_next = take ? '{wr: hwrite, rd: !hwrite, addr: haddr} : '0;
    assign wbyte    = hwdata[7:0];
    assign wr_high  = acc_reg.wr && hit(acc_reg, vdc_pkg::ADDR_CODE_HIGH);
    assign wr_low   = acc_reg.wr && hit(acc_reg, vdc_pkg::ADDR_CODE_LOW);
    assign wr_ctrl  = acc_reg.wr && hit(acc_reg, vdc_pkg::ADDR_CONTROL);
    assign rd_now   = take && !hwrite;

    // next register values, also what a read in the same cycle returns
    assign shadow_next    = wr_low ? wbyte : shadow_reg;
    assign code_high_next = wr_high ? wbyte : code_high_reg;
    assign code_low_next  = wr_high ? shadow_reg : code_low_reg;
    assign enable_next    = wr_ctrl ? wbyte[vdc_pkg::ENABLE_BIT] : enable_reg;

    // read mux in address phase; a write in its data phase is seen; unmapped reads zero
    assign rdata_next =
        !rd_now ? rdata_reg :
        (haddr == vdc_pkg::ADDR_CODE_HIGH) ? {24'h000000, code_high_next} :
        (haddr == vdc_pkg::ADDR_CODE_LOW)  ? {24'h000000, code_low_next} :
        (haddr == vdc_pkg::ADDR_CONTROL)   ? {31'h00000000, enable_next} :
        (haddr == vdc_pkg::ADDR_STATUS)    ? {30'h00000000, busy, settled} :
        32'h00000000;

    // converter word launched on high write, using new high and shadow low
    assign dac_next = '{enable: enable_reg,
                        code:   wr_high ? {wbyte, shadow_reg} : dac_reg.code,
                        load:   wr_high};

    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;
    assign hrdata               = rdata_reg;
    assign converter_code       = dac_reg.code;
    assign converter_load       = dac_reg.load;
    assign converter_power_down = !dac_reg.enable;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_reg   <= '0;
            rdata_reg <= 32'h00000000;
            dac_reg   <= '0;
        end
        else
        begin
            acc_reg   <= acc_next;
            rdata_reg <= rdata_next;
            dac_reg   <= dac_next;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            code_high_reg <= vdc_pkg::RESET_CODE_HIGH;
            code_low_reg  <= vdc_pkg::RESET_CODE_LOW;
            shadow_reg    <= vdc_pkg::RESET_CODE_LOW;
            enable_reg    <= vdc_pkg::RESET_CONTROL[vdc_pkg::ENABLE_BIT];
        end
        else
        begin
            code_high_reg <= code_high_next;
            code_low_reg  <= code_low_next;
            shadow_reg    <= shadow_next;
            enable_reg    <= enable_next;
        end
    end

    vdc_settle u_settle
    (
        .mclk    (mclk),
        .resetn  (resetn),
        .enable  (enable_reg),
        .load    (dac_reg.load),
        .settled (settled),
        .busy    (busy)
    );

    // converter word and shadow buffer
    a_high_loads : assert property (@(posedge mclk) disable iff (!resetn)
        wr_high |=> converter_load && converter_code == {$past(wbyte), $past(shadow_reg)})
        else $error("high write did not load code");
    a_low_no_load : assert property (@(posedge mclk) disable iff (!resetn)
        wr_low && !wr_high |=> !converter_load && $stable(converter_code))
        else $error("low write changed output");
    a_low_copy : assert property (@(posedge mclk) disable iff (!resetn)
        wr_high |=> code_low_reg == $past(shadow_reg))
        else $error("shadow not copied");
    a_high_store : assert property (@(posedge mclk) disable iff (!resetn)
        wr_high |=> code_high_reg == $past(wbyte))
        else $error("high byte not stored");
    a_code_halves : assert property (@(posedge mclk) disable iff (!resetn)
        converter_load |-> converter_code == {code_high_reg, code_low_reg})
        else $error("code differs from register halves");
    a_shadow_take : assert property (@(posedge mclk) disable iff (!resetn)
        wr_low |=> shadow_reg == $past(wbyte))
        else $error("low byte not buffered");
    a_shadow_hold : assert property (@(posedge mclk) disable iff (!resetn)
        !wr_low |=> $stable(shadow_reg))
        else $error("shadow changed without low write");
    a_regs_hold : assert property (@(posedge mclk) disable iff (!resetn)
        !wr_high |=> $stable(code_high_reg) && $stable(code_low_reg))
        else $error("code registers changed without high write");
    a_code_hold : assert property (@(posedge mclk) disable iff (!resetn)
        !converter_load |-> $stable(converter_code))
        else $error("code changed without load");
    a_no_load_idle : assert property (@(posedge mclk) disable iff (!resetn)
        !wr_high |=> !converter_load)
        else $error("spurious load");
    a_load_busy : assert property (@(posedge mclk) disable iff (!resetn)
        converter_load |=> busy)
        else $error("load did not start conversion");

    // enable bit and analog power
    a_enable_bit : assert property (@(posedge mclk) disable iff (!resetn)
        wr_ctrl |=> enable_reg == $past(wbyte[vdc_pkg::ENABLE_BIT]))
        else $error("enable not taken from bit 0");
    a_enable_hold : assert property (@(posedge mclk) disable iff (!resetn)
        !wr_ctrl |=> $stable(enable_reg))
        else $error("enable changed without control write");
    a_power_down : assert property (@(posedge mclk) disable iff (!resetn)
        !enable_reg |=> converter_power_down)
        else $error("powered while disabled");
    a_power_up : assert property (@(posedge mclk) disable iff (!resetn)
        enable_reg |=> !converter_power_down)
        else $error("powered down while enabled");

    // read data stands in the data phase, with the value it commits
    a_ctrl_zero : assert property (@(posedge mclk) disable iff (!resetn)
        rd_now && haddr == vdc_pkg::ADDR_CONTROL |=> hrdata[31:1] == 31'h00000000)
        else $error("control upper bits not zero");
    a_ctrl_read : assert property (@(posedge mclk) disable iff (!resetn)
        rd_now && haddr == vdc_pkg::ADDR_CONTROL |=> hrdata == {31'h00000000, enable_reg})
        else $error("control read wrong");
    a_low_read : assert property (@(posedge mclk) disable iff (!resetn)
        rd_now && haddr == vdc_pkg::ADDR_CODE_LOW |=> hrdata == {24'h000000, code_low_reg})
        else $error("low read not committed value");
    a_high_read : assert property (@(posedge mclk) disable iff (!resetn)
        rd_now && haddr == vdc_pkg::ADDR_CODE_HIGH |=> hrdata == {24'h000000, code_high_reg})
        else $error("high read wrong");
    a_status_off : assert property (@(posedge mclk) disable iff (!resetn)
        rd_now && haddr == vdc_pkg::ADDR_STATUS && !enable_reg
            |=> !hrdata[vdc_pkg::STATUS_SETTLED])
        else $error("settled read while disabled");
    a_status_read : assert property (@(posedge mclk) disable iff (!resetn)
        rd_now && haddr == vdc_pkg::ADDR_STATUS |=> hrdata[31:2] == 30'h00000000)
        else $error("status upper bits not zero");
    a_unmapped_read : assert property (@(posedge mclk) disable iff (!resetn)
        rd_now && haddr > vdc_pkg::ADDR_STATUS |=> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_read_steady : assert property (@(posedge mclk) disable iff (!resetn)
        !rd_now |=> $stable(hrdata))
        else $error("read data changed without read");

    // main scenarios
    c_low_then_high : cover property (@(posedge mclk) disable iff (!resetn)
        wr_low ##[1:8] wr_high);
    c_enable_settle : cover property (@(posedge mclk) disable iff (!resetn)
        wr_ctrl ##1 enable_reg ##[1:300] settled);
    c_read_low : cover property (@(posedge mclk) disable iff (!resetn)
        rd_now && haddr == vdc_pkg::ADDR_CODE_LOW);
    c_load_busy : cover property (@(posedge mclk) disable iff (!resetn)
        converter_load ##1 busy);
    c_read_status : cover property (@(posedge mclk) disable iff (!resetn)
        acc_reg.rd && hit(acc_reg, vdc_pkg::ADDR_STATUS));

endmodule

// File: test/vdc_ladder_model.sv
`timescale 1ns/1ns
module vdc_ladder_model
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [15:0] code,
    input  wire logic        load,
    input  wire logic        power_down,
    output logic [15:0]      level,
    output logic [31:0]      loads
);
    logic [15:0] held;
    // unpowered ladder drives zero
    assign level = power_down ? 16'h0000 : held;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            held  <= 16'h0000;
            loads <= 32'h00000000;
        end
        else if (load)
        begin
            held  <= code;
            loads <= loads + 32'h00000001;
        end
    end
endmodule

// File: test/voice_dac_control_tb.sv
`timescale 1ns/1ns
module voice_dac_control_tb;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [15:0] code;
    logic        load;
    logic        pdn;
    logic [15:0] level;
    logic [31:0] rd;
    logic [31:0] loads;
    int          err_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    always #20 mclk = ~mclk;
    vdc_top dut
    (
        .mclk                 (mclk),
        .resetn               (resetn),
        .hsel                 (hsel),
        .haddr                (haddr),
        .htrans               (htrans),
        .hwrite               (hwrite),
        .hsize                (vdc_pkg::HSIZE_WORD),
        .hwdata               (hwdata),
        .hready               (hreadyout),
        .hrdata               (hrdata),
        .hreadyout            (hreadyout),
        .hresp                (hresp),
        .converter_code       (code),
        .converter_load       (load),
        .converter_power_down (pdn)
    );
    vdc_ladder_model ladder
    (
        .mclk       (mclk),
        .resetn     (resetn),
        .code       (code),
        .load       (load),
        .power_down (pdn),
        .level      (level),
        .loads      (loads)
    );
    task automatic end_sim;
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one single word transfer, read data left in rd
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= vdc_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        repeat (2) @(negedge mclk);
    endtask
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            err_count++;
            end_sim();
        end
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        xfer(1'b0, vdc_pkg::ADDR_CODE_HIGH, 32'h0);
        check("code_high", {24'h0, vdc_pkg::RESET_CODE_HIGH}, rd);
        check("hresp", 32'h0, {31'h0, hresp});
        check("hreadyout", 32'h1, {31'h0, hreadyout});
        xfer(1'b0, vdc_pkg::ADDR_CODE_LOW, 32'h0);
        check("code_low", {24'h0, vdc_pkg::RESET_CODE_LOW}, rd);
        xfer(1'b0, vdc_pkg::ADDR_CONTROL, 32'h0);
        check("control", {24'h0, vdc_pkg::RESET_CONTROL}, rd);
        check("power_down", 32'h1, {31'h0, pdn});
        xfer(1'b1, vdc_pkg::ADDR_CONTROL, 32'hFFFFFFFF);
        xfer(1'b0, vdc_pkg::ADDR_CONTROL, 32'h0);
        check("control", 32'h1, rd);
        check("power_down", 32'h0, {31'h0, pdn});
        repeat (vdc_pkg::SETTLE_CYCLES) @(posedge mclk);
        xfer(1'b0, vdc_pkg::ADDR_STATUS, 32'h0);
        check("status", 32'h1 << vdc_pkg::STATUS_SETTLED, rd);
        xfer(1'b1, vdc_pkg::ADDR_CODE_LOW, 32'h5A);
        check("code", 32'h0, {16'h0, code});
        check("loads", 32'h0, loads);
        xfer(1'b0, vdc_pkg::ADDR_CODE_LOW, 32'h0);
        check("code_low", 32'h0, rd);
        xfer(1'b1, vdc_pkg::ADDR_CODE_HIGH, 32'hA3);
        check("code", 32'hA35A, {16'h0, code});
        check("level", 32'hA35A, {16'h0, level});
        check("loads", 32'h1, loads);
        xfer(1'b0, vdc_pkg::ADDR_STATUS, 32'h0);
        check("busy", 32'h1, {31'h0, rd[vdc_pkg::STATUS_BUSY]});
        check("settled", 32'h1, {31'h0, rd[vdc_pkg::STATUS_SETTLED]});
        xfer(1'b0, vdc_pkg::ADDR_CODE_LOW, 32'h0);
        check("code_low", 32'h5A, rd);
        xfer(1'b0, vdc_pkg::ADDR_CODE_HIGH, 32'h0);
        check("code_high", 32'hA3, rd);
        xfer(1'b1, vdc_pkg::ADDR_CODE_LOW, 32'hC4);
        xfer(1'b1, vdc_pkg::ADDR_CODE_HIGH, 32'h11);
        check("code", 32'h11C4, {16'h0, code});
        xfer(1'b1, vdc_pkg::ADDR_CODE_HIGH, 32'h22);
        check("code", 32'h22C4, {16'h0, code});
        check("loads", 32'h3, loads);
        xfer(1'b1, vdc_pkg::ADDR_CONTROL, 32'hFFFFFFFE);
        check("power_down", 32'h1, {31'h0, pdn});
        check("level", 32'h0, {16'h0, level});
        xfer(1'b0, vdc_pkg::ADDR_STATUS, 32'h0);
        check("status", 32'h0, rd);
        xfer(1'b1, 12'h010, 32'hFFFFFFFF);
        xfer(1'b0, 12'h010, 32'h0);
        check("unmapped", 32'h0, rd);
        end_sim();
    end
endmodule
